// *** design/iaem_addr_match.sv ***
// ipv4 address filter: any, host or masked network
`timescale 1ns/100ps
`default_nettype none
module iaem_addr_match (
    input  wire iaem_pkg::iaem_addr_cfg_t cfg,
    input  wire logic [31:0]              frame_addr,
    output logic                          match
);

    // host ignores the mask; network compares only the masked bits
    always_comb begin
        unique case (cfg.sel)
            iaem_pkg::ASEL_HOST:
                match = (frame_addr == cfg.addr);
            iaem_pkg::ASEL_NETWORK:
                match = ((frame_addr & cfg.mask) == (cfg.addr & cfg.mask));
            default:
                match = 1'b1;
        endcase
    end

endmodule
`default_nettype wire

// *** design/iaem_matcher.sv ***
// top of the ipv4 acl entry matcher with its apb register file
//
// Notes on behaviour
// - ipv4 criteria apply only for ipv4 frame type
// - protocol any ignores the protocol field
// - icmp/udp/tcp match protocol, enable extra criteria
// - specific compares protocol with configured byte
// - ttl zero setting rejects ttl above zero
// - ttl non-zero admits ttl above zero
// - fragment is mf set or offset nonzero
// - options criterion: no, yes or any
// - source any ignores the source address
// - source host needs exact address equality
// - source network compares under source mask
// - destination any ignores destination address
// - destination host needs exact address equality
// - destination network compares under destination mask
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module iaem_matcher (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                frame_valid,
    input  wire iaem_pkg::iaem_hdr_t frame_hdr,
    output logic                     result_valid,
    output logic                     entry_hit,
    output logic                     icmp_criteria_en,
    output logic                     udp_criteria_en,
    output logic                     tcp_criteria_en
);

    // configuration and status registers
    logic [31:0] ctrl_ff;
    logic [31:0] proto_ff;
    logic [31:0] src_addr_ff;
    logic [31:0] src_mask_ff;
    logic [31:0] dst_addr_ff;
    logic [31:0] dst_mask_ff;
    logic [31:0] hit_cnt_ff;
    logic [31:0] nxt_hit_cnt;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic [iaem_pkg::NUM_CRIT-1:0] crit_ff;
    logic        last_hit_ff;
    logic        result_valid_ff;
    logic        entry_hit_ff;
    logic        icmp_en_ff;
    logic        udp_en_ff;
    logic        tcp_en_ff;

    // bus decode
    logic        setup_rd;
    logic        acc;
    logic        acc_wr;
    logic        mapped;
    logic [31:0] strb_mask;

    // decoded configuration fields
    logic        entry_en;
    logic [1:0]  ftype_sel;
    logic [2:0]  proto_sel;
    logic [1:0]  ttl_sel;
    logic [1:0]  frag_sel;
    logic [1:0]  opt_sel;
    logic [7:0]  proto_val;
    iaem_pkg::iaem_addr_cfg_t src_cfg;
    iaem_pkg::iaem_addr_cfg_t dst_cfg;

    // per-criterion results for the frame on the input
    logic        ipv4_applies;
    logic        ftype_ok;
    logic        proto_ok;
    logic        ttl_raw;
    logic        frag_raw;
    logic        opt_raw;
    logic        src_raw;
    logic        dst_raw;
    logic        is_fragment;
    logic        ttl_nonzero;
    logic [iaem_pkg::NUM_CRIT-1:0] crit;
    logic        hit_now;

    // apb: zero wait states; read data is latched in the setup cycle
    assign setup_rd = psel && !penable && !pwrite;
    assign acc      = psel && penable;
    assign acc_wr   = acc && pwrite && mapped;
    assign pready   = acc;
    assign pslverr  = acc && !mapped;
    assign prdata   = prdata_ff;

    // the read-only registers accept no write data; a write there is
    // an error except the counter, whose write clears it
    always_comb begin
        unique case (paddr)
            iaem_pkg::ADDR_CTRL,
            iaem_pkg::ADDR_PROTO,
            iaem_pkg::ADDR_SRC_ADDR,
            iaem_pkg::ADDR_SRC_MASK,
            iaem_pkg::ADDR_DST_ADDR,
            iaem_pkg::ADDR_DST_MASK,
            iaem_pkg::ADDR_HIT_CNT: mapped = 1'b1;
            iaem_pkg::ADDR_STATUS:  mapped = !pwrite;
            default:                mapped = 1'b0;
        endcase
    end

    // byte lanes expanded to a bit mask, one lane per loop pass
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_lane
            assign strb_mask[lane*8 +: 8] = {8{pstrb[lane]}};
        end
    endgenerate

    // read mux feeding the registered read data
    always_comb begin
        nxt_prdata = prdata_ff;
        if (setup_rd) begin
            unique case (paddr)
                iaem_pkg::ADDR_CTRL:     nxt_prdata = ctrl_ff;
                iaem_pkg::ADDR_PROTO:    nxt_prdata = proto_ff;
                iaem_pkg::ADDR_SRC_ADDR: nxt_prdata = src_addr_ff;
                iaem_pkg::ADDR_SRC_MASK: nxt_prdata = src_mask_ff;
                iaem_pkg::ADDR_DST_ADDR: nxt_prdata = dst_addr_ff;
                iaem_pkg::ADDR_DST_MASK: nxt_prdata = dst_mask_ff;
                iaem_pkg::ADDR_STATUS: begin
                    nxt_prdata = iaem_pkg::WORD_RST;
                    nxt_prdata[iaem_pkg::STAT_HIT] = last_hit_ff;
                    nxt_prdata[iaem_pkg::STAT_CRIT +: iaem_pkg::NUM_CRIT] =
                        crit_ff;
                end
                iaem_pkg::ADDR_HIT_CNT:  nxt_prdata = hit_cnt_ff;
                default:                 nxt_prdata = iaem_pkg::WORD_RST;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= iaem_pkg::WORD_RST;
        end else begin
            prdata_ff <= nxt_prdata;
        end
    end

    // entry control; reserved bits never store, so they read as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= iaem_pkg::CTRL_RST;
        end else if (acc_wr && paddr == iaem_pkg::ADDR_CTRL) begin
            ctrl_ff <= (ctrl_ff & ~strb_mask) |
                       (pwdata & strb_mask & iaem_pkg::CTRL_WMASK);
        end
    end

    // protocol value, an 8-bit field covering 0 to 255
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            proto_ff <= iaem_pkg::WORD_RST;
        end else if (acc_wr && paddr == iaem_pkg::ADDR_PROTO) begin
            proto_ff <= (proto_ff & ~strb_mask) |
                        (pwdata & strb_mask & iaem_pkg::PROTO_WMASK);
        end
    end

    // source address filter words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_addr_ff <= iaem_pkg::WORD_RST;
            src_mask_ff <= iaem_pkg::MASK_RST;
        end else if (acc_wr) begin
            if (paddr == iaem_pkg::ADDR_SRC_ADDR) begin
                src_addr_ff <= (src_addr_ff & ~strb_mask) |
                               (pwdata & strb_mask);
            end
            if (paddr == iaem_pkg::ADDR_SRC_MASK) begin
                src_mask_ff <= (src_mask_ff & ~strb_mask) |
                               (pwdata & strb_mask);
            end
        end
    end

    // destination address filter words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dst_addr_ff <= iaem_pkg::WORD_RST;
            dst_mask_ff <= iaem_pkg::MASK_RST;
        end else if (acc_wr) begin
            if (paddr == iaem_pkg::ADDR_DST_ADDR) begin
                dst_addr_ff <= (dst_addr_ff & ~strb_mask) |
                               (pwdata & strb_mask);
            end
            if (paddr == iaem_pkg::ADDR_DST_MASK) begin
                dst_mask_ff <= (dst_mask_ff & ~strb_mask) |
                               (pwdata & strb_mask);
            end
        end
    end

    // field decode of the control word
    assign entry_en  = ctrl_ff[iaem_pkg::CTRL_EN];
    assign ftype_sel = ctrl_ff[iaem_pkg::CTRL_FTYPE +: 2];
    assign proto_sel = ctrl_ff[iaem_pkg::CTRL_PROTO +: 3];
    assign ttl_sel   = ctrl_ff[iaem_pkg::CTRL_TTL +: 2];
    assign frag_sel  = ctrl_ff[iaem_pkg::CTRL_FRAG +: 2];
    assign opt_sel   = ctrl_ff[iaem_pkg::CTRL_OPT +: 2];
    assign proto_val = proto_ff[7:0];

    assign src_cfg.sel  = ctrl_ff[iaem_pkg::CTRL_SRC +: 2];
    assign src_cfg.addr = src_addr_ff;
    assign src_cfg.mask = src_mask_ff;
    assign dst_cfg.sel  = ctrl_ff[iaem_pkg::CTRL_DST +: 2];
    assign dst_cfg.addr = dst_addr_ff;
    assign dst_cfg.mask = dst_mask_ff;

    // frame type: any leaves ipv4 criteria unused; other types never hit
    // here because their criteria live in a sibling block
    assign ipv4_applies = (ftype_sel == iaem_pkg::FTYPE_IPV4);
    always_comb begin
        unique case (ftype_sel)
            iaem_pkg::FTYPE_ANY:  ftype_ok = 1'b1;
            iaem_pkg::FTYPE_IPV4: ftype_ok = frame_hdr.is_ipv4;
            default:              ftype_ok = 1'b0;
        endcase
    end

    // protocol criterion
    always_comb begin
        unique case (proto_sel)
            iaem_pkg::PSEL_ANY:
                proto_ok = 1'b1;
            iaem_pkg::PSEL_SPECIFIC:
                proto_ok = (frame_hdr.protocol == proto_val);
            iaem_pkg::PSEL_ICMP:
                proto_ok = frame_hdr.protocol == iaem_pkg::IPPROTO_ICMP;
            iaem_pkg::PSEL_UDP:
                proto_ok = frame_hdr.protocol == iaem_pkg::IPPROTO_UDP;
            iaem_pkg::PSEL_TCP:
                proto_ok = frame_hdr.protocol == iaem_pkg::IPPROTO_TCP;
            default:
                proto_ok = 1'b1;
        endcase
    end

    // flag inputs of the three-way criteria
    assign ttl_nonzero = (frame_hdr.ttl != 8'h00);
    assign is_fragment = frame_hdr.more_frag ||
                         (frame_hdr.frag_offset != 13'h0000);

    // zero demands ttl of zero, non-zero demands ttl above zero
    iaem_tri_match u_ttl (
        .sel   (ttl_sel),
        .flag  (ttl_nonzero),
        .match (ttl_raw)
    );

    iaem_tri_match u_frag (
        .sel   (frag_sel),
        .flag  (is_fragment),
        .match (frag_raw)
    );

    iaem_tri_match u_opt (
        .sel   (opt_sel),
        .flag  (frame_hdr.has_options),
        .match (opt_raw)
    );

    // address filters; masked compare anded on both sides
    iaem_addr_match u_src (
        .cfg        (src_cfg),
        .frame_addr (frame_hdr.source_ip_address),
        .match      (src_raw)
    );

    iaem_addr_match u_dst (
        .cfg        (dst_cfg),
        .frame_addr (frame_hdr.destination_ip_address),
        .match      (dst_raw)
    );

    // ipv4 criteria count as matched when the entry is not an ipv4 one
    assign crit[0] = ftype_ok;
    assign crit[1] = !ipv4_applies || proto_ok;
    assign crit[2] = !ipv4_applies || ttl_raw;
    assign crit[3] = !ipv4_applies || frag_raw;
    assign crit[4] = !ipv4_applies || opt_raw;
    assign crit[5] = !ipv4_applies || src_raw;
    assign crit[6] = !ipv4_applies || dst_raw;

    // all criteria at once; a disabled entry never hits
    assign hit_now = frame_valid && entry_en && (&crit);

    // one-cycle result pulses, registered so the data outputs are clean
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_valid_ff <= 1'b0;
            entry_hit_ff    <= 1'b0;
        end else begin
            result_valid_ff <= frame_valid;
            entry_hit_ff    <= hit_now;
        end
    end

    // outcome of the last frame, kept for software to inspect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_hit_ff <= 1'b0;
            crit_ff     <= '0;
        end else if (frame_valid) begin
            last_hit_ff <= hit_now;
            crit_ff     <= crit;
        end
    end

    // hit counter; a hit in the clearing cycle survives as a count of one
    always_comb begin
        nxt_hit_cnt = hit_cnt_ff;
        if (acc_wr && paddr == iaem_pkg::ADDR_HIT_CNT) begin
            nxt_hit_cnt = iaem_pkg::WORD_RST;
        end
        if (hit_now) begin
            nxt_hit_cnt = nxt_hit_cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit_cnt_ff <= iaem_pkg::WORD_RST;
        end else begin
            hit_cnt_ff <= nxt_hit_cnt;
        end
    end

    // protocol-specific sub-criteria are only enabled for ipv4 entries
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            icmp_en_ff <= 1'b0;
            udp_en_ff  <= 1'b0;
            tcp_en_ff  <= 1'b0;
        end else begin
            icmp_en_ff <= ipv4_applies && proto_sel == iaem_pkg::PSEL_ICMP;
            udp_en_ff  <= ipv4_applies && proto_sel == iaem_pkg::PSEL_UDP;
            tcp_en_ff  <= ipv4_applies && proto_sel == iaem_pkg::PSEL_TCP;
        end
    end

    assign result_valid     = result_valid_ff;
    assign entry_hit        = entry_hit_ff;
    assign icmp_criteria_en = icmp_en_ff;
    assign udp_criteria_en  = udp_en_ff;
    assign tcp_criteria_en  = tcp_en_ff;

endmodule
`default_nettype wire

// *** design/iaem_pkg.sv ***
// package: register map, field layout and codes of the ipv4 acl entry matcher
package iaem_pkg;

    // register byte offsets, one aligned 32-bit word each
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_PROTO    = 8'h04;
    localparam logic [7:0] ADDR_SRC_ADDR = 8'h08;
    localparam logic [7:0] ADDR_SRC_MASK = 8'h0c;
    localparam logic [7:0] ADDR_DST_ADDR = 8'h10;
    localparam logic [7:0] ADDR_DST_MASK = 8'h14;
    localparam logic [7:0] ADDR_STATUS   = 8'h18;
    localparam logic [7:0] ADDR_HIT_CNT  = 8'h1c;

    // control field positions
    localparam int CTRL_EN     = 0;
    localparam int CTRL_FTYPE  = 1;
    localparam int CTRL_PROTO  = 4;
    localparam int CTRL_TTL    = 8;
    localparam int CTRL_FRAG   = 10;
    localparam int CTRL_OPT    = 12;
    localparam int CTRL_SRC    = 16;
    localparam int CTRL_DST    = 18;
    localparam logic [31:0] CTRL_WMASK = 32'h000f_3f77;
    localparam logic [31:0] PROTO_WMASK = 32'h0000_00ff;

    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [31:0] MASK_RST = 32'hffff_ffff;

    // status field positions
    localparam int STAT_HIT  = 0;
    localparam int STAT_CRIT = 1;
    localparam int NUM_CRIT  = 7;

    // frame type setting
    localparam logic [1:0] FTYPE_ANY  = 2'h0;
    localparam logic [1:0] FTYPE_IPV4 = 2'h1;

    // protocol selector codes
    localparam logic [2:0] PSEL_ANY      = 3'h0;
    localparam logic [2:0] PSEL_SPECIFIC = 3'h1;
    localparam logic [2:0] PSEL_ICMP     = 3'h2;
    localparam logic [2:0] PSEL_UDP      = 3'h3;
    localparam logic [2:0] PSEL_TCP      = 3'h4;

    // ip protocol numbers
    localparam logic [7:0] IPPROTO_ICMP = 8'h01;
    localparam logic [7:0] IPPROTO_TCP  = 8'h06;
    localparam logic [7:0] IPPROTO_UDP  = 8'h11;

    // three-way criterion codes: any, no (zero), yes (non-zero)
    localparam logic [1:0] TRI_ANY = 2'h0;
    localparam logic [1:0] TRI_NO  = 2'h1;
    localparam logic [1:0] TRI_YES = 2'h2;

    // address selector codes
    localparam logic [1:0] ASEL_ANY     = 2'h0;
    localparam logic [1:0] ASEL_HOST    = 2'h1;
    localparam logic [1:0] ASEL_NETWORK = 2'h2;

    // parsed ipv4 header fields of one received frame
    typedef struct packed {
        logic        is_ipv4;
        logic [7:0]  protocol;
        logic [7:0]  ttl;
        logic        more_frag;
        logic [12:0] frag_offset;
        logic        has_options;
        logic [31:0] source_ip_address;
        logic [31:0] destination_ip_address;
    } iaem_hdr_t;

    // one address filter setting
    typedef struct packed {
        logic [1:0]  sel;
        logic [31:0] addr;
        logic [31:0] mask;
    } iaem_addr_cfg_t;

endpackage

// *** design/iaem_tri_match.sv ***
// three-way flag criterion: any, must be clear, must be set
`timescale 1ns/100ps
`default_nettype none
module iaem_tri_match (
    input  wire logic [1:0] sel,
    input  wire logic       flag,
    output logic            match
);

    // an unused code falls back to don't-care so a bad write never blocks
    always_comb begin
        unique case (sel)
            iaem_pkg::TRI_NO:  match = !flag;
            iaem_pkg::TRI_YES: match = flag;
            default:           match = 1'b1;
        endcase
    end

endmodule
`default_nettype wire

// *** verif/iaem_matcher_chk.sv ***
// checker: port-level timing and hit properties of the acl entry matcher
`timescale 1ns/100ps
`default_nettype none
module iaem_matcher_chk (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic                frame_valid,
    input wire iaem_pkg::iaem_hdr_t frame_hdr,
    input wire logic                result_valid,
    input wire logic                entry_hit,
    input wire logic                icmp_criteria_en,
    input wire logic                udp_criteria_en,
    input wire logic                tcp_criteria_en
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // gated with reset so a frame offered during reset expects no answer
    property p_resp;
        result_valid == $past(frame_valid && presetn);
    endproperty
    a_resp: assert property (p_resp)
        else $error("result pulse not one cycle after frame");
    property p_hit_vld;
        entry_hit |-> result_valid;
    endproperty
    a_hit_vld: assert property (p_hit_vld)
        else $error("hit without result pulse");
    property p_rdy;
        pready == (psel && penable);
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready outside access");
    property p_err;
        pslverr |-> psel && penable;
    endproperty
    a_err: assert property (p_err) else $error("error outside access");
    property p_onehot;
        $onehot0({icmp_criteria_en, udp_criteria_en, tcp_criteria_en});
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("more than one protocol criteria enable");
    property p_icmp;
        entry_hit && icmp_criteria_en |->
            $past(frame_hdr.protocol) == iaem_pkg::IPPROTO_ICMP;
    endproperty
    a_icmp: assert property (p_icmp)
        else $error("icmp entry hit by other protocol");
    property p_udp;
        entry_hit && udp_criteria_en |->
            $past(frame_hdr.protocol) == iaem_pkg::IPPROTO_UDP;
    endproperty
    a_udp: assert property (p_udp)
        else $error("udp entry hit by other protocol");
    property p_tcp;
        entry_hit && tcp_criteria_en |->
            $past(frame_hdr.protocol) == iaem_pkg::IPPROTO_TCP;
    endproperty
    a_tcp: assert property (p_tcp)
        else $error("tcp entry hit by other protocol");
    property p_v4;
        entry_hit && (icmp_criteria_en || udp_criteria_en
            || tcp_criteria_en) |-> $past(frame_hdr.is_ipv4);
    endproperty
    a_v4: assert property (p_v4)
        else $error("ipv4 entry hit by non-ipv4 frame");
    // enables follow a control write by exactly two edges
    property p_en_chg;
        $changed({icmp_criteria_en, udp_criteria_en, tcp_criteria_en})
            |-> $past(psel && penable && pwrite, 2);
    endproperty
    a_en_chg: assert property (p_en_chg)
        else $error("criteria enable changed without write");

    c_hit: cover property (entry_hit);
    c_miss: cover property (result_valid && !entry_hit);
    c_err: cover property (pslverr);
    c_tcp: cover property (entry_hit && tcp_criteria_en);
endmodule
`default_nettype wire

// *** verif/test_ipv4_acl_entry_matcher.sv ***
// testbench: random and corner checks of the acl entry matcher
`timescale 1ns/100ps
`default_nettype none
module test_ipv4_acl_entry_matcher;
    logic                pclk, presetn, psel, penable, pwrite;
    logic [7:0]          paddr;
    logic [31:0]         pwdata, prdata;
    logic [3:0]          pstrb;
    logic                pready, pslverr, frame_valid;
    iaem_pkg::iaem_hdr_t frame_hdr;
    logic                result_valid, entry_hit;
    logic                icmp_en, udp_en, tcp_en;
    logic [31:0]         ctrl, prv, sa, sm, da, dm;
    logic                last;
    int                  err_total, n_checks, hits;

    iaem_matcher i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .frame_valid(frame_valid), .frame_hdr(frame_hdr),
        .result_valid(result_valid), .entry_hit(entry_hit),
        .icmp_criteria_en(icmp_en), .udp_criteria_en(udp_en),
        .tcp_criteria_en(tcp_en));

    always #12.5 pclk = ~pclk;

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // one apb transfer; only the watchdog bounds the wait for pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    function automatic logic tri_ok(logic [1:0] c, logic f);
        return c == iaem_pkg::TRI_NO ? !f : c == iaem_pkg::TRI_YES ? f : 1;
    endfunction

    function automatic logic adr_ok(logic [1:0] s,
                                    logic [31:0] a, m, f);
        if (s == iaem_pkg::ASEL_HOST)
            return f == a;
        return s == iaem_pkg::ASEL_NETWORK ? (f & m) == (a & m) : 1'b1;
    endfunction

    // reference decision for one frame against the current settings
    function automatic logic exp_hit(iaem_pkg::iaem_hdr_t h);
        logic p;
        case (ctrl[6:4])
            iaem_pkg::PSEL_SPECIFIC: p = h.protocol == prv[7:0];
            iaem_pkg::PSEL_ICMP: p = h.protocol == iaem_pkg::IPPROTO_ICMP;
            iaem_pkg::PSEL_UDP: p = h.protocol == iaem_pkg::IPPROTO_UDP;
            iaem_pkg::PSEL_TCP: p = h.protocol == iaem_pkg::IPPROTO_TCP;
            default: p = 1'b1;
        endcase
        if (!ctrl[0] || ctrl[2:1] > iaem_pkg::FTYPE_IPV4)
            return 1'b0;
        if (ctrl[2:1] == iaem_pkg::FTYPE_ANY)
            return 1'b1;
        return h.is_ipv4 && p && tri_ok(ctrl[9:8], h.ttl != 0)
            && tri_ok(ctrl[11:10], h.more_frag || h.frag_offset != 0)
            && tri_ok(ctrl[13:12], h.has_options)
            && adr_ok(ctrl[17:16], sa, sm, h.source_ip_address)
            && adr_ok(ctrl[19:18], da, dm, h.destination_ip_address);
    endfunction

    // headers biased toward the configured values so hits occur
    function automatic iaem_pkg::iaem_hdr_t rnd_hdr();
        iaem_pkg::iaem_hdr_t h;
        logic [7:0] pl [4];
        pl = '{iaem_pkg::IPPROTO_ICMP, iaem_pkg::IPPROTO_UDP,
               iaem_pkg::IPPROTO_TCP, prv[7:0]};
        h.is_ipv4 = $urandom % 8 != 0;
        h.protocol = $urandom % 5 == 4 ? 8'($urandom) : pl[$urandom % 4];
        h.ttl = $urandom % 2 ? 8'h00 : 8'($urandom);
        h.more_frag = $urandom % 4 == 0;
        h.frag_offset = $urandom % 4 == 0 ? 13'($urandom) : 13'h0000;
        h.has_options = 1'($urandom);
        h.source_ip_address = sa ^ ($urandom % 2 ? 32'h0
            : $urandom >> ($urandom % 32));
        h.destination_ip_address = da ^ ($urandom % 2 ? 32'h0
            : $urandom >> ($urandom % 32));
        return h;
    endfunction

    task automatic frame(input iaem_pkg::iaem_hdr_t h);
        last = exp_hit(h);
        @(posedge pclk);
        frame_valid <= 1'b1;
        frame_hdr <= h;
        @(posedge pclk);
        frame_valid <= 1'b0;
        #1;
        chk("result_valid", {31'h0, result_valid}, 32'h1);
        chk("entry_hit", {31'h0, entry_hit}, {31'h0, last});
        hits += int'(last);
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        end_of_test();
    end

    initial begin
        int i;
        logic [31:0] r;
        logic e;
        logic v4;
        {pclk, presetn, psel, penable, pwrite, frame_valid} = '0;
        {paddr, pwdata, frame_hdr} = '0;
        pstrb = 4'hf;
        {err_total, n_checks, hits} = '0;
        r = $urandom(32'haa7ad4cf);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, then one unmapped word
        for (i = 0; i < 9; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0, r, e);
            chk("reset value", r, (i == 3 || i == 5) ? iaem_pkg::MASK_RST
                : iaem_pkg::WORD_RST);
            chk("slverr", {31'h0, e}, {31'h0, i == 8});
        end
        wr(iaem_pkg::ADDR_CTRL, 32'hffff_ffff);
        apb(1'b0, iaem_pkg::ADDR_CTRL, 32'h0, r, e);
        chk("ctrl reserved", r, iaem_pkg::CTRL_WMASK);
        apb(1'b1, iaem_pkg::ADDR_STATUS, 32'hffff_ffff, r, e);
        chk("status write err", {31'h0, e}, 32'h1);
        wr(iaem_pkg::ADDR_HIT_CNT, 32'h0);
        // every protocol selector code comes round five times
        for (i = 0; i < 40; i++) begin
            ctrl = $urandom & iaem_pkg::CTRL_WMASK;
            ctrl[0] = i % 8 != 7;
            ctrl[6:4] = 3'(i);
            if ($urandom % 4 != 0)
                ctrl[2:1] = iaem_pkg::FTYPE_IPV4;
            prv = $urandom & iaem_pkg::PROTO_WMASK;
            {sa, da} = {$urandom, $urandom};
            sm = 32'hffff_ffff << ($urandom % 32);
            dm = 32'hffff_ffff << ($urandom % 32);
            wr(iaem_pkg::ADDR_CTRL, ctrl);
            wr(iaem_pkg::ADDR_PROTO, prv);
            wr(iaem_pkg::ADDR_SRC_ADDR, sa);
            wr(iaem_pkg::ADDR_SRC_MASK, sm);
            wr(iaem_pkg::ADDR_DST_ADDR, da);
            wr(iaem_pkg::ADDR_DST_MASK, dm);
            @(posedge pclk);
            #1;
            v4 = ctrl[2:1] == iaem_pkg::FTYPE_IPV4;
            chk("criteria_en", {29'h0, icmp_en, udp_en, tcp_en},
                {29'h0, v4 && ctrl[6:4] == iaem_pkg::PSEL_ICMP,
                 v4 && ctrl[6:4] == iaem_pkg::PSEL_UDP,
                 v4 && ctrl[6:4] == iaem_pkg::PSEL_TCP});
            repeat (8) frame(rnd_hdr());
            apb(1'b0, iaem_pkg::ADDR_STATUS, 32'h0, r, e);
            chk("status hit", {31'h0, r[0]}, {31'h0, last});
        end
        apb(1'b0, iaem_pkg::ADDR_HIT_CNT, 32'h0, r, e);
        chk("hit count", r, 32'(hits));
        end_of_test();
    end
endmodule

bind iaem_matcher iaem_matcher_chk i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .frame_valid(frame_valid), .frame_hdr(frame_hdr),
    .result_valid(result_valid), .entry_hit(entry_hit),
    .icmp_criteria_en(icmp_criteria_en),
    .udp_criteria_en(udp_criteria_en), .tcp_criteria_en(tcp_criteria_en));
`default_nettype wire
